// [bench/smis_props.sv]
// Port assertions for the masked status block
`default_nettype none
module smis_props(
input wire logic I_MCLK,I_RESET_N,I_PSEL,I_PENABLE,I_PWRITE,
input wire logic [11:0] I_PADDR,input wire logic [31:0] I_PWDATA,
input wire logic O_PREADY,O_PSLVERR,input wire logic [31:0] O_PRDATA,
input wire logic [6:0] I_EVENT,input wire logic O_IRQ);
default clocking @(posedge I_MCLK); endclocking
default disable iff (!I_RESET_N);
wire m=I_PADDR==12'h050||I_PADDR==12'h054||I_PADDR==12'h058;
wire w=I_PWRITE;
sequence s_acc; I_PSEL&&I_PENABLE; endsequence
property p_rdy; s_acc|->O_PREADY; endproperty
a_rdy: assert property(p_rdy) else $error("no ready");
property p_rsv; s_acc##0!w|->O_PRDATA[31:7]==0; endproperty
a_rsv: assert property(p_rsv) else $error("high bits set");
property p_unm; s_acc##0!m|->O_PSLVERR&&(w||O_PRDATA==0); endproperty
a_unm: assert property(p_unm) else $error("unmapped");
property p_map; s_acc##0 m|->!O_PSLVERR; endproperty
a_map: assert property(p_map) else $error("false error");
// Only stable pins: a fresh edge may win over the clear
property p_clr; s_acc##0(w&&I_PADDR==12'h058&&I_PWDATA[6:0]==7'h7F&&$stable(I_EVENT))
|->##[1:2]!O_IRQ; endproperty
a_clr: assert property(p_clr) else $error("irq after clear");
property p_msk; s_acc##0(w&&I_PADDR==12'h054&&I_PWDATA[6:0]==7'h00)|->##[1:2]!O_IRQ;
endproperty
a_msk: assert property(p_msk) else $error("irq unmasked");
endmodule // smis_props
bind smis_top smis_props u_props(.*);
`default_nettype wire

// [bench/smis_top_test.sv]
// Self-checking bench for the masked status block
`default_nettype none
module smis_top_test;
timeunit 1ns; timeprecision 1ns;
logic c=0,rn=0,ps=0,pe=0,pw=0,se;
logic [11:0] pa=0; logic [31:0] pd=0,r; logic [6:0] ev=0;
wire rdy,err,irq; wire [31:0] prd;
int error_cnt=0,num_checks=0,raw=0,msk=0,w,i;
smis_top u_dut(.I_MCLK(c),.I_RESET_N(rn),.I_PSEL(ps),.I_PENABLE(pe),.I_PWRITE(pw),
.I_PADDR(pa),.I_PWDATA(pd),.O_PREADY(rdy),.O_PSLVERR(err),.O_PRDATA(prd),
.I_EVENT(ev),.O_IRQ(irq));
initial forever #5 c=~c;
task wrap_up;
$display("checks %0d errors %0d",num_checks,error_cnt);
if(error_cnt==0&&num_checks>0) $display("RESULT: PASS");
else $display("RESULT: FAIL");
$finish;
endtask
task chk(input logic [31:0] s,e);
num_checks++;
if(s!==e) begin error_cnt++; $display("unexpected %0t mismatch %h %h",$time,s,e); end
endtask
// Ready is waited for, never assumed
task apb(input logic wr,input logic [11:0] a,input logic [31:0] d);
int n;
ps<=1; pw<=wr; pa<=a; pd<=d; @(posedge c); pe<=1; n=0;
do begin @(posedge c); n++; end while(rdy!==1'b1&&n<20);
if(n>=20) begin error_cnt++; wrap_up; end
r=prd; se=err; ps<=0; pe<=0; @(posedge c);
endtask
initial begin
void'($urandom(7)); repeat(12) @(posedge c); rn<=1; @(posedge c);
apb(0,12'h058,0); chk(r,0);
for(i=0;i<6;i++) begin
w=$urandom; ev<=0; apb(1,12'h054,w); msk=w&'h7F;
apb(0,12'h054,0); chk(r,msk);
chk(se,0);
repeat(8) @(posedge c); ev<=w[14:8]; raw|=w[14:8]; repeat(8) @(posedge c);
apb(0,12'h050,0); chk(r,raw);
apb(0,12'h058,0); chk(r,raw&msk);
chk(irq,(raw&msk)!=0);
apb(1,12'h058,w|'hFFFFFF80); raw&=~(w&msk);
apb(0,12'h058,0); chk(r,raw&msk);
apb(0,12'h050,0); chk(r,raw);
$display("test %0d done",i);
end
apb(1,12'h054,0); repeat(2) @(posedge c); chk(irq,0);
apb(1,12'h054,'h7F); apb(1,12'h058,'h7F); repeat(2) @(posedge c);
chk(irq,0);
apb(0,12'h050,0); chk(r,0);
apb(0,12'h05C,0); chk(r,0);
chk(se,1);
$display("final test done");
wrap_up;
end
endmodule // smis_top_test
`default_nettype wire

// [hdl/smis_regs.vh]
// Register map constants for the masked system interrupt status block
`ifndef SMIS_REGS_VH
`define SMIS_REGS_VH
`define SMIS_RAW_OFFSET        12'h050
`define SMIS_MASK_OFFSET       12'h054
`define SMIS_CLEAR_OFFSET      12'h058
`define SMIS_NUM_EVENTS        7
`define SMIS_PLL_FAULT_BIT     0
`define SMIS_BROWNOUT_BIT      1
`define SMIS_REGULATOR_BIT     2
`define SMIS_MAIN_OSC_BIT      3
`define SMIS_INT_OSC_BIT       4
`define SMIS_CURRENT_LIMIT_BIT 5
`define SMIS_PLL_LOCK_BIT      6
`define SMIS_RESET_VALUE       7'h00
`endif

// [hdl/smis_sync.v]
// Three-stage synchroniser with agreement check for one event pin
`default_nettype none
module smis_sync
(
    // Clock and reset
    input  wire i_clk,
    input  wire i_reset_n,
    // Pin and result
    input  wire i_pin,
    output reg  o_level
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;

    // The first stage feeds only the second to keep metastability contained
    always @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            s1_reg  <= 1'b0;
            s2_reg  <= 1'b0;
            s3_reg  <= 1'b0;
            o_level <= 1'b0;
        end
        else
        begin
            s1_reg <= i_pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg)
                o_level <= s3_reg;
        end
    end
endmodule // smis_sync
`default_nettype wire

// [hdl/smis_top.v]
// Masked system interrupt status controller with APB register access
// Function
// - Masked bit is raw AND mask; any masked bit drives the interrupt.
// - Writing one clears masked and raw bit; writing zero changes nothing. The code clears the raw bit only where the mask bit is set.
// - Bit 5 reports current-limit masked status, write-one-to-clear, resets zero.
// - Current-limit masked bit sets when the regulator limit event asserts and enabled.
// - Set mask passes raw bit to interrupt; clear mask blocks; same positions.
//
// Our own choice: the APB register port.
`include "smis_regs.vh"
`default_nettype none
module smis_top
(
    // Clock and reset
    input  wire        I_MCLK,
    input  wire        I_RESET_N,
    // APB slave
    input  wire        I_PSEL,
    input  wire        I_PENABLE,
    input  wire        I_PWRITE,
    input  wire [11:0] I_PADDR,
    input  wire [31:0] I_PWDATA,
    output wire        O_PREADY,
    output wire        O_PSLVERR,
    output reg  [31:0] O_PRDATA,
    // Event pins, one per source, level high while the condition stands
    input  wire [6:0]  I_EVENT,
    // Interrupt to processor
    output reg         O_IRQ
);
    localparam N = `SMIS_NUM_EVENTS;

    wire [N-1:0] event_sync;
    reg  [N-1:0] event_prev_reg;
    reg  [N-1:0] raw_event_status_reg;
    reg  [N-1:0] event_enable_mask_reg;
    reg  [N-1:0] raw_next;
    wire [N-1:0] masked;
    wire [N-1:0] event_rise;
    wire         access;
    wire         wr;
    wire         addr_ok;
    wire [N-1:0] clear_bits;
    reg  [31:0]  rdata_next;

    genvar g;
    generate
        for (g = 0; g < N; g = g + 1)
        begin : gen_sync
            smis_sync u_sync
            (
                .i_clk     (I_MCLK),
                .i_reset_n (I_RESET_N),
                .i_pin     (I_EVENT[g]),
                .o_level   (event_sync[g])
            );
        end
    endgenerate

    // Zero wait-state slave
    assign O_PREADY  = 1'b1;
    assign access    = I_PSEL & I_PENABLE;
    assign wr        = access & I_PWRITE;
    assign addr_ok   = (I_PADDR == `SMIS_RAW_OFFSET) | (I_PADDR == `SMIS_MASK_OFFSET)
                     | (I_PADDR == `SMIS_CLEAR_OFFSET);
    assign O_PSLVERR = access & ~addr_ok;

    // Events latch on the rising edge so a standing condition is not re-latched after a clear
    assign event_rise = event_sync & ~event_prev_reg;
    assign masked     = raw_event_status_reg & event_enable_mask_reg;
    // Upper write bits fall outside the 7-bit slice and are dropped
    assign clear_bits = (wr && I_PADDR == `SMIS_CLEAR_OFFSET) ? I_PWDATA[N-1:0] : {N{1'b0}};

    always @*
    begin
        // Clearing a masked bit also clears the raw bit; a new event wins the cycle
        raw_next = (raw_event_status_reg & ~(clear_bits & masked)) | event_rise;
    end

    always @*
    begin
        rdata_next = 32'h00000000;
        if (I_PADDR == `SMIS_RAW_OFFSET)
            rdata_next[N-1:0] = raw_event_status_reg;
        else if (I_PADDR == `SMIS_MASK_OFFSET)
            rdata_next[N-1:0] = event_enable_mask_reg;
        else if (I_PADDR == `SMIS_CLEAR_OFFSET)
            rdata_next[N-1:0] = masked;
    end

    always @(posedge I_MCLK)
    begin
        if (!I_RESET_N)
        begin
            event_prev_reg        <= `SMIS_RESET_VALUE;
            raw_event_status_reg  <= `SMIS_RESET_VALUE;
            event_enable_mask_reg <= `SMIS_RESET_VALUE;
            O_PRDATA              <= 32'h00000000;
            O_IRQ                 <= 1'b0;
        end
        else
        begin
            event_prev_reg       <= event_sync;
            raw_event_status_reg <= raw_next;
            if (wr && I_PADDR == `SMIS_MASK_OFFSET)
                event_enable_mask_reg <= I_PWDATA[N-1:0];
            if (I_PSEL && !I_PENABLE && !I_PWRITE)
                O_PRDATA <= rdata_next;
            O_IRQ <= |(raw_next & event_enable_mask_reg);
        end
    end
endmodule // smis_top
`default_nettype wire
